// >>> include/efcu_defines.vh
// efcu_defines.vh: constants for the embedded flash command unit
`ifndef EFCU_DEFINES_VH
`define EFCU_DEFINES_VH
// register byte offsets
`define EFCU_A_MODE 4'h0
`define EFCU_A_CMD 4'h4
`define EFCU_A_STAT 4'h8
`define EFCU_A_NVM 4'hC
// mode register fields and reset values
`define EFCU_WS_LSB 0
`define EFCU_WS_RST 4'h1
`define EFCU_IE_DONE 8
`define EFCU_IE_ERR 9
`define EFCU_TIM_LSB 16
`define EFCU_TIM_RST 8'h04
// command register fields
`define EFCU_CMD_LSB 0
`define EFCU_ARG_LSB 16
// status register bits
`define EFCU_ST_RDY 0
`define EFCU_ST_DONE 1
`define EFCU_ST_LOCKE 2
`define EFCU_ST_CMDE 3
`define EFCU_ST_SEC 4
`define EFCU_ST_FPM 5
`define EFCU_ST_LOCK_LSB 16
// nvm register fields
`define EFCU_NVM_GP_LSB 0
`define EFCU_NVM_CAL_LSB 8
// command codes
`define EFCU_C_PROG 4'h1
`define EFCU_C_PERASE 4'h2
`define EFCU_C_FERASE 4'h3
`define EFCU_C_SLOCK 4'h4
`define EFCU_C_CLOCK 4'h5
`define EFCU_C_SGP 4'h6
`define EFCU_C_CGP 4'h7
`define EFCU_C_SSEC 4'h8
`define EFCU_C_READ 4'h9
// array geometry
`define EFCU_PAGES 1024
`define EFCU_WPP 64
`define EFCU_WORDS 65536
`define EFCU_REGIONS 16
`define EFCU_PG_LAST 16'h003F
`define EFCU_FULL_LAST 16'hFFFF
`define EFCU_ERASED 32'hFFFFFFFF
// general nvm bits
`define EFCU_GP_CNT 16'h0003
`define EFCU_GP_BODEN 0
`define EFCU_GP_BODRST 1
`define EFCU_GP_BOOT 2
// factory calibration, value arbitrary
`define EFCU_CALIB_RST 8'h00
// erase pin least hold time
`define EFCU_ERASE_MS 220
`define EFCU_CLK_KHZ 250000
`define EFCU_ERASE_CYC (`EFCU_ERASE_MS * `EFCU_CLK_KHZ)
`define EFCU_CNT_W 26
`endif

// >>> core/efcu_erase_filter.v
// efcu_erase_filter.v: erase pin synchroniser and hold-time filter
`timescale 1ns/1ps
`include "efcu_defines.vh"
module efcu_erase_filter #(
  parameter integer MIN_CYC = `EFCU_ERASE_CYC
)
(
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire pin_in,
  output wire held_out
);
  reg sync1_ff;
  reg sync2_ff;
  reg held_ff;
  reg [`EFCU_CNT_W-1:0] cnt_ff;
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end
  // short pulses never reach the nvm bits
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in || !sync2_ff)
    begin
      cnt_ff <= {`EFCU_CNT_W{1'b0}};
      held_ff <= 1'b0;
    end
    else if (!held_ff)
    begin
      cnt_ff <= cnt_ff + 26'h1;
      if ({6'h00, cnt_ff} >= MIN_CYC - 1)
        held_ff <= 1'b1;
    end
  end
  assign held_out = held_ff;
endmodule // efcu_erase_filter

// >>> core/efcu_top.v
// efcu_top.v: embedded flash command unit for one flash plane
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "efcu_defines.vh"
// Overview of operation
// - 1024 pages of 256 bytes, word access
// - 256-byte page buffer filled by words
// - array in standby when nothing runs
// - software sets wait states, timing, commands
// - done and error status, maskable interrupt
// - two-word prefetch serves consecutive halfword fetches
// - one unit per plane, planes independent
// - sixteen lock bits, 64 pages each
// - locked erase or program aborts, flags error
// - set-lock protects, clear-lock unprotects region
// - erase pin clears every lock bit
// - secure part refuses debug and fastprog access
// - security set by command, cleared by full erase after erase pin
// - set and clear commands on nvm bits
// - nvm bit 0 enables brownout detector
// - nvm bit 1 enables brownout reset
// - calibration bits fixed, erase pin ignored
// - fast mode needs test and selects high
// - fastprog port runs the full command set
// - boot source sampled from nvm bit 2 just after reset, which clears it, so it stays 0
// - erase pin clears boot select bit
module efcu_top #(
  parameter integer ERASE_MIN_CYC = `EFCU_ERASE_CYC,
  parameter [7:0] CALIB_BITS = `EFCU_CALIB_RST
)
(
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [31:0] reg_rdata_out,
  input wire fetch_req_in,
  input wire [17:0] fetch_addr_in,
  input wire fetch_dbg_in,
  output wire fetch_ready_out,
  output wire fetch_ack_out,
  output wire fetch_err_out,
  output wire [31:0] fetch_data_out,
  input wire wbuf_wr_in,
  input wire [5:0] wbuf_addr_in,
  input wire [31:0] wbuf_data_in,
  input wire test_mode_pin_in,
  input wire program_select_0_in,
  input wire program_select_1_in,
  input wire erase_pin_in,
  input wire fprog_valid_in,
  input wire [3:0] fprog_cmd_in,
  input wire [15:0] fprog_arg_in,
  output wire fprog_busy_out,
  output wire fprog_done_out,
  output wire fprog_err_out,
  output wire [31:0] fprog_rdata_out,
  output wire irq_out,
  output wire fast_prog_mode_out,
  output wire flash_standby_out,
  output wire brownout_detector_en_out,
  output wire brownout_reset_en_out,
  output wire boot_from_flash_out,
  output wire [7:0] calib_bits_out
);
  localparam [1:0] F_IDLE = 2'h0;
  localparam [1:0] F_RD = 2'h1;
  localparam [1:0] F_PF = 2'h2;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_STEP = 2'h1;
  reg [31:0] flash_mem [0:`EFCU_WORDS-1];
  reg [31:0] wbuf_mem [0:`EFCU_WPP-1];
  reg [15:0] pf_tag_ff [0:1];
  reg [31:0] pf_data_ff [0:1];
  reg [1:0] pf_vld_ff;
  reg fill_ix_ff;
  reg [1:0] f_state_ff;
  reg [3:0] wcnt_ff;
  reg [15:0] mem_addr_ff;
  reg f_ack_ff;
  reg f_err_ff;
  reg [31:0] f_data_ff;
  reg [1:0] s_state_ff;
  reg [3:0] s_op_ff;
  reg s_src_fp_ff;
  reg [15:0] s_base_ff;
  reg [15:0] s_idx_ff;
  reg [15:0] s_last_ff;
  reg [7:0] s_dly_ff;
  reg [3:0] ws_ff;
  reg [7:0] tim_ff;
  reg ie_done_ff;
  reg ie_err_ff;
  reg done_ff;
  reg locke_ff;
  reg cmde_ff;
  reg irq_ff;
  reg sec_ff;
  reg sec_arm_ff;
  reg [2:0] gen_nvm_ff;
  reg [15:0] lock_ff;
  reg fast_mode_ff;
  reg held_prev_ff;
  reg standby_ff;
  reg boot_ff;
  reg boot_seen_ff;
  reg fp_done_ff;
  reg fp_err_ff;
  reg [31:0] fp_rdata_ff;
  reg [31:0] rdata_ff;
  reg bad_cmd;
  wire erase_held;
  efcu_erase_filter #(
    .MIN_CYC(ERASE_MIN_CYC)
  )
  u_erase_filter
  (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(erase_pin_in),
    .held_out(erase_held)
  );
  wire erase_hit = erase_held && !held_prev_ff;
  wire seq_free = (s_state_ff == S_IDLE) && (f_state_ff == F_IDLE);
  wire reg_cmd = reg_wr_in && (reg_addr_in == `EFCU_A_CMD);
  // port only live in fast mode
  wire fp_take = fprog_valid_in && fast_mode_ff && seq_free && !reg_cmd;
  wire fp_deny = fp_take && sec_ff;
  wire go = (reg_cmd && seq_free) || (fp_take && !sec_ff);
  wire busy_cmd = reg_cmd && !seq_free;
  wire [3:0] cmd = fp_take ? fprog_cmd_in : reg_wdata_in[3:0];
  wire [15:0] arg = fp_take ? fprog_arg_in : reg_wdata_in[31:16];
  wire [3:0] region = arg[9:6];
  wire is_wr = (cmd == `EFCU_C_PROG) || (cmd == `EFCU_C_PERASE);
  wire gp_ok = arg < `EFCU_GP_CNT;
  wire lock_abort = go && !bad_cmd && ((is_wr && lock_ff[region]) ||
    ((cmd == `EFCU_C_FERASE) && (|lock_ff)));
  wire ok = go && !bad_cmd && !lock_abort;
  wire start = ok && (is_wr || (cmd == `EFCU_C_FERASE));
  wire stat_rd = reg_rd_in && (reg_addr_in == `EFCU_A_STAT);
  wire mem_we = (s_state_ff == S_STEP) && (s_dly_ff == 8'h00);
  wire seq_end = mem_we && (s_idx_ff == s_last_ff);
  wire [15:0] s_waddr = s_base_ff + s_idx_ff;
  wire [15:0] f_word = fetch_addr_in[17:2];
  wire hit0 = pf_vld_ff[0] && (pf_tag_ff[0] == f_word);
  wire hit1 = pf_vld_ff[1] && (pf_tag_ff[1] == f_word);
  wire [31:0] rd_word = flash_mem[mem_addr_ff];
  // full command set on fastprog; read refused from the register port
  always @*
  begin
    case (cmd)
      `EFCU_C_PROG, `EFCU_C_PERASE, `EFCU_C_FERASE,
      `EFCU_C_SLOCK, `EFCU_C_CLOCK, `EFCU_C_SSEC:
        bad_cmd = 1'b0;
      `EFCU_C_SGP, `EFCU_C_CGP:
        bad_cmd = !gp_ok;
      `EFCU_C_READ:
        bad_cmd = !fp_take;
      default:
        bad_cmd = 1'b1;
    endcase
  end
  // one lock bit per 64-page region
  genvar gi;
  generate
    for (gi = 0; gi < `EFCU_REGIONS; gi = gi + 1)
    begin : g_lock
      always @(posedge ref_clk_in)
      begin
        if (!rst_b_in)
          lock_ff[gi] <= 1'b0;
        else if (erase_hit)
          lock_ff[gi] <= 1'b0;
        else if (ok && (region == gi) && (cmd == `EFCU_C_SLOCK))
          lock_ff[gi] <= 1'b1;
        else if (ok && (region == gi) && (cmd == `EFCU_C_CLOCK))
          lock_ff[gi] <= 1'b0;
      end
    end
  endgenerate
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      ws_ff <= `EFCU_WS_RST;
      tim_ff <= `EFCU_TIM_RST;
      ie_done_ff <= 1'b0;
      ie_err_ff <= 1'b0;
      done_ff <= 1'b0;
      locke_ff <= 1'b0;
      cmde_ff <= 1'b0;
      irq_ff <= 1'b0;
      sec_ff <= 1'b0;
      sec_arm_ff <= 1'b0;
      gen_nvm_ff <= 3'h0;
      fast_mode_ff <= 1'b0;
      held_prev_ff <= 1'b0;
      standby_ff <= 1'b1;
      boot_ff <= 1'b0;
      boot_seen_ff <= 1'b0;
      fp_done_ff <= 1'b0;
      fp_err_ff <= 1'b0;
      fp_rdata_ff <= 32'h00000000;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == `EFCU_A_MODE))
      begin
        ws_ff <= reg_wdata_in[`EFCU_WS_LSB+3:`EFCU_WS_LSB];
        tim_ff <= reg_wdata_in[`EFCU_TIM_LSB+7:`EFCU_TIM_LSB];
        ie_done_ff <= reg_wdata_in[`EFCU_IE_DONE];
        ie_err_ff <= reg_wdata_in[`EFCU_IE_ERR];
      end
      // sticky status, new event beats read clear
      done_ff <= (go && !start) || seq_end || (done_ff && !stat_rd);
      locke_ff <= lock_abort || (locke_ff && !stat_rd);
      cmde_ff <= (go && bad_cmd) || busy_cmd || (cmde_ff && !stat_rd);
      irq_ff <= (done_ff && ie_done_ff) ||
        ((locke_ff || cmde_ff) && ie_err_ff);
      // set by command, cleared by erase then full erase
      if (ok && (cmd == `EFCU_C_SSEC))
        sec_ff <= 1'b1;
      else if (seq_end && (s_op_ff == `EFCU_C_FERASE) && sec_arm_ff)
        sec_ff <= 1'b0;
      if (erase_hit)
        sec_arm_ff <= 1'b1;
      else if (seq_end && (s_op_ff == `EFCU_C_FERASE))
        sec_arm_ff <= 1'b0;
      // erase pin clears all general bits
      if (erase_hit)
        gen_nvm_ff <= 3'h0;
      // set and clear general nvm bit
      else if (ok && (cmd == `EFCU_C_SGP))
        gen_nvm_ff[arg[1:0]] <= 1'b1;
      else if (ok && (cmd == `EFCU_C_CGP))
        gen_nvm_ff[arg[1:0]] <= 1'b0;
      fast_mode_ff <= test_mode_pin_in && program_select_0_in &&
        program_select_1_in;
      held_prev_ff <= erase_held;
      standby_ff <= (f_state_ff == F_IDLE) && (s_state_ff == S_IDLE) &&
        !(fetch_req_in && fetch_ready_out) && !start;
      // boot source caught after reset release
      boot_seen_ff <= 1'b1;
      if (!boot_seen_ff)
        boot_ff <= gen_nvm_ff[`EFCU_GP_BOOT];
      fp_done_ff <= (fp_take && !sec_ff && !start) ||
        (seq_end && s_src_fp_ff);
      fp_err_ff <= fp_deny || (fp_take && !sec_ff && !ok);
      if (ok && fp_take && (cmd == `EFCU_C_READ))
        fp_rdata_ff <= flash_mem[arg];
    end
  end
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      rdata_ff <= 32'h00000000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `EFCU_A_MODE:
          rdata_ff <= {8'h00, tim_ff, 6'h00, ie_err_ff, ie_done_ff,
            4'h0, ws_ff};
        `EFCU_A_STAT:
          rdata_ff <= {lock_ff, 10'h000, fast_mode_ff, sec_ff, cmde_ff,
            locke_ff, done_ff, s_state_ff == S_IDLE};
        `EFCU_A_NVM:
          rdata_ff <= {16'h0000, CALIB_BITS, 5'h00, gen_nvm_ff};
        default:
          rdata_ff <= 32'h00000000;
      endcase
    end
  end
  // page buffer written one word at a time
  always @(posedge ref_clk_in)
  begin
    if (wbuf_wr_in)
      wbuf_mem[wbuf_addr_in] <= wbuf_data_in;
  end
  // word-wide array, no reset as in real cells
  always @(posedge ref_clk_in)
  begin
    if (mem_we)
      flash_mem[s_waddr] <= (s_op_ff == `EFCU_C_PROG) ?
        wbuf_mem[s_idx_ff[5:0]] : `EFCU_ERASED;
  end
  // one word per timing interval keeps the sequencer tiny
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      s_state_ff <= S_IDLE;
      s_op_ff <= 4'h0;
      s_src_fp_ff <= 1'b0;
      s_base_ff <= 16'h0000;
      s_idx_ff <= 16'h0000;
      s_last_ff <= 16'h0000;
      s_dly_ff <= 8'h00;
    end
    else
    begin
      case (s_state_ff)
        S_IDLE:
        begin
          if (start)
          begin
            s_state_ff <= S_STEP;
            s_op_ff <= cmd;
            s_src_fp_ff <= fp_take;
            s_idx_ff <= 16'h0000;
            s_dly_ff <= tim_ff;
            if (cmd == `EFCU_C_FERASE)
            begin
              s_base_ff <= 16'h0000;
              s_last_ff <= `EFCU_FULL_LAST;
            end
            else
            begin
              s_base_ff <= {arg[9:0], 6'h00};
              s_last_ff <= `EFCU_PG_LAST;
            end
          end
        end
        S_STEP:
        begin
          if (s_dly_ff != 8'h00)
            s_dly_ff <= s_dly_ff - 8'h01;
          else if (s_idx_ff == s_last_ff)
            s_state_ff <= S_IDLE;
          else
          begin
            s_idx_ff <= s_idx_ff + 16'h0001;
            s_dly_ff <= tim_ff;
          end
        end
        default:
          s_state_ff <= S_IDLE;
      endcase
    end
  end
  // two-entry prefetch, miss also loads next word
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      f_state_ff <= F_IDLE;
      pf_vld_ff <= 2'b00;
      fill_ix_ff <= 1'b0;
      wcnt_ff <= 4'h0;
      mem_addr_ff <= 16'h0000;
      f_ack_ff <= 1'b0;
      f_err_ff <= 1'b0;
      f_data_ff <= 32'h00000000;
    end
    else
    begin
      f_ack_ff <= 1'b0;
      f_err_ff <= 1'b0;
      // stale words must not survive an array write
      if (mem_we)
        pf_vld_ff <= 2'b00;
      case (f_state_ff)
        F_IDLE:
        begin
          if (fetch_req_in && fetch_ready_out)
          begin
            // secure part refuses debug probe reads
            if (fetch_dbg_in && sec_ff)
            begin
              f_ack_ff <= 1'b1;
              f_err_ff <= 1'b1;
            end
            else if (hit0 || hit1)
            begin
              f_ack_ff <= 1'b1;
              f_data_ff <= hit0 ? pf_data_ff[0] : pf_data_ff[1];
            end
            else
            begin
              mem_addr_ff <= f_word;
              wcnt_ff <= ws_ff;
              f_state_ff <= F_RD;
            end
          end
        end
        F_RD:
        begin
          if (wcnt_ff != 4'h0)
            wcnt_ff <= wcnt_ff - 4'h1;
          else
          begin
            pf_tag_ff[fill_ix_ff] <= mem_addr_ff;
            pf_data_ff[fill_ix_ff] <= rd_word;
            pf_vld_ff[fill_ix_ff] <= 1'b1;
            f_data_ff <= rd_word;
            f_ack_ff <= 1'b1;
            fill_ix_ff <= !fill_ix_ff;
            mem_addr_ff <= mem_addr_ff + 16'h0001;
            wcnt_ff <= ws_ff;
            f_state_ff <= F_PF;
          end
        end
        F_PF:
        begin
          if (wcnt_ff != 4'h0)
            wcnt_ff <= wcnt_ff - 4'h1;
          else
          begin
            pf_tag_ff[fill_ix_ff] <= mem_addr_ff;
            pf_data_ff[fill_ix_ff] <= rd_word;
            pf_vld_ff[fill_ix_ff] <= 1'b1;
            fill_ix_ff <= !fill_ix_ff;
            f_state_ff <= F_IDLE;
          end
        end
        default:
          f_state_ff <= F_IDLE;
      endcase
    end
  end
  // only this plane's work stalls its reads
  assign fetch_ready_out = (f_state_ff == F_IDLE) &&
    (s_state_ff == S_IDLE) && !go;
  assign fetch_ack_out = f_ack_ff;
  assign fetch_err_out = f_err_ff;
  assign fetch_data_out = f_data_ff;
  assign fprog_busy_out = !(fast_mode_ff && seq_free);
  assign fprog_done_out = fp_done_ff;
  assign fprog_err_out = fp_err_ff;
  assign fprog_rdata_out = fp_rdata_ff;
  assign reg_rdata_out = rdata_ff;
  assign irq_out = irq_ff;
  assign fast_prog_mode_out = fast_mode_ff;
  assign flash_standby_out = standby_ff;
  assign brownout_detector_en_out = gen_nvm_ff[`EFCU_GP_BODEN];
  assign brownout_reset_en_out = gen_nvm_ff[`EFCU_GP_BODRST];
  assign boot_from_flash_out = boot_ff;
  assign calib_bits_out = CALIB_BITS;
endmodule // efcu_top

// >>> test/efcu_checker.sv
// efcu_checker.sv: port assertions for the flash command unit
`timescale 1ns/1ps
`include "efcu_defines.vh"
module efcu_checker #(
  parameter integer ERASE_MIN_CYC = 16,
  parameter [7:0] CALIB_BITS = 8'h00
)
(
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [3:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire fetch_req_in,
  input wire fetch_dbg_in,
  input wire fetch_ready_out,
  input wire fetch_ack_out,
  input wire fetch_err_out,
  input wire test_mode_pin_in,
  input wire program_select_0_in,
  input wire program_select_1_in,
  input wire erase_pin_in,
  input wire fprog_valid_in,
  input wire [3:0] fprog_cmd_in,
  input wire fprog_busy_out,
  input wire fprog_done_out,
  input wire fprog_err_out,
  input wire fast_prog_mode_out,
  input wire brownout_detector_en_out,
  input wire brownout_reset_en_out,
  input wire boot_from_flash_out,
  input wire [7:0] calib_bits_out
);
  reg [31:0] hi_cnt_ff;
  reg [1:0] rel_cnt_ff;
  reg last_dbg_ff;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // margin covers sync and output flops
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      hi_cnt_ff <= 32'h0;
      rel_cnt_ff <= 2'h0;
      last_dbg_ff <= 1'b0;
    end
    else
    begin
      hi_cnt_ff <= erase_pin_in ? hi_cnt_ff + 32'h1 : 32'h0;
      rel_cnt_ff <= (rel_cnt_ff == 2'h3) ? 2'h3 : rel_cnt_ff + 2'h1;
      if (fetch_req_in && fetch_ready_out)
        last_dbg_ff <= fetch_dbg_in;
    end
  end
  calib_fixed_a: assert property (
    calib_bits_out == CALIB_BITS) else $error("calib bits moved");
  fast_mode_a: assert property (
    !(test_mode_pin_in && program_select_0_in && program_select_1_in)
    |=> !fast_prog_mode_out) else $error("fast mode without straps");
  fast_gate_a: assert property (
    !fast_prog_mode_out |-> fprog_busy_out) else $error("port open");
  erase_clr_a: assert property (
    hi_cnt_ff == ERASE_MIN_CYC + 6 |->
    !brownout_detector_en_out && !brownout_reset_en_out)
    else $error("erase pin left nvm bits set");
  dbg_err_a: assert property (
    fetch_err_out |-> fetch_ack_out && last_dbg_ff)
    else $error("fetch error without debug request");
  ack_bound_a: assert property (
    fetch_req_in && fetch_ready_out |-> ##[1:17] fetch_ack_out)
    else $error("fetch not answered");
  fp_answer_a: assert property (
    fprog_valid_in && !fprog_busy_out && !reg_wr_in &&
    fprog_cmd_in == `EFCU_C_READ |=> fprog_done_out || fprog_err_out)
    else $error("fast read not answered");
  boot_hold_a: assert property (
    rel_cnt_ff == 2'h3 |=> $stable(boot_from_flash_out))
    else $error("boot select moved after reset");
  nvm_read_a: assert property (
    reg_rd_in && reg_addr_in == `EFCU_A_NVM |=>
    reg_rdata_out[1:0] == {$past(brownout_reset_en_out),
    $past(brownout_detector_en_out)} && reg_rdata_out[15:8] == CALIB_BITS)
    else $error("nvm read mismatch");
  unmapped_a: assert property (
    reg_rd_in && (reg_addr_in[1:0] != 2'h0 || reg_addr_in == `EFCU_A_CMD)
    |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
endmodule // efcu_checker
bind efcu_top efcu_checker #(.ERASE_MIN_CYC(ERASE_MIN_CYC),
  .CALIB_BITS(CALIB_BITS)) chk_u (.ref_clk_in, .rst_b_in, .reg_addr_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .fetch_req_in, .fetch_dbg_in,
  .fetch_ready_out, .fetch_ack_out, .fetch_err_out, .test_mode_pin_in,
  .program_select_0_in, .program_select_1_in, .erase_pin_in,
  .fprog_valid_in, .fprog_cmd_in, .fprog_busy_out, .fprog_done_out,
  .fprog_err_out, .fast_prog_mode_out, .brownout_detector_en_out,
  .brownout_reset_en_out, .boot_from_flash_out, .calib_bits_out);

// >>> test/efcu_fetch_master.sv
// efcu_fetch_master.sv: bus master model on the fetch port
`timescale 1ns/1ps
module efcu_fetch_master
(
  input wire ref_clk_in,
  input wire fetch_ready_in,
  input wire fetch_ack_in,
  input wire fetch_err_in,
  input wire [31:0] fetch_data_in,
  output reg fetch_req_out,
  output reg [17:0] fetch_addr_out,
  output reg fetch_dbg_out
);
  initial
  begin
    fetch_req_out = 1'b0;
    fetch_addr_out = 18'h0;
    fetch_dbg_out = 1'b0;
  end
  // one request outstanding; released lines show the inverse
  task fetch(input [17:0] a, input d, output [31:0] q, output e);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk_in);
      fetch_req_out <= 1'b1;
      fetch_addr_out <= a;
      fetch_dbg_out <= d;
      @(negedge ref_clk_in);
      while (fetch_ready_in !== 1'b1 && n < 64)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      @(posedge ref_clk_in);
      fetch_req_out <= 1'b0;
      fetch_addr_out <= ~a;
      fetch_dbg_out <= ~d;
      @(negedge ref_clk_in);
      while (fetch_ack_in !== 1'b1 && n < 128)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      q = fetch_data_in;
      e = fetch_err_in;
      // prefetch keeps ready low; register commands would be refused
      while (fetch_ready_in !== 1'b1 && n < 192)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
    end
  endtask
endmodule // efcu_fetch_master

// >>> test/efcu_top_tb.sv
// efcu_top_tb.sv: self-checking bench for the flash command unit
`timescale 1ns/1ps
`include "efcu_defines.vh"
module efcu_top_tb;
  reg ref_clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg [3:0] reg_addr_in = 4'h0;
  reg [31:0] reg_wdata_in = 32'h0;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg wbuf_wr_in = 1'b0;
  reg [5:0] wbuf_addr_in = 6'h0;
  reg [31:0] wbuf_data_in = 32'h0;
  reg test_mode_pin_in = 1'b0;
  reg program_select_0_in = 1'b0;
  reg program_select_1_in = 1'b0;
  reg erase_pin_in = 1'b0;
  reg fprog_valid_in = 1'b0;
  reg [3:0] fprog_cmd_in = 4'h0;
  reg [15:0] fprog_arg_in = 16'h0;
  wire [31:0] reg_rdata_out, fetch_data_out, fprog_rdata_out;
  wire [17:0] fetch_addr_in;
  wire [7:0] calib_bits_out;
  wire fetch_req_in, fetch_dbg_in, fetch_ready_out, fetch_ack_out;
  wire fetch_err_out, fprog_busy_out, fprog_done_out, fprog_err_out;
  wire irq_out, fast_prog_mode_out, flash_standby_out, boot_from_flash_out;
  wire brownout_detector_en_out, brownout_reset_en_out;
  integer errors = 0;
  integer n_checks = 0;
  integer cyc = 0, i;
  reg [31:0] q, s;
  reg e;
  efcu_top #(.ERASE_MIN_CYC(16)) dut_u (.ref_clk_in, .rst_b_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .fetch_req_in, .fetch_addr_in, .fetch_dbg_in, .fetch_ready_out,
    .fetch_ack_out, .fetch_err_out, .fetch_data_out, .wbuf_wr_in,
    .wbuf_addr_in, .wbuf_data_in, .test_mode_pin_in, .program_select_0_in,
    .program_select_1_in, .erase_pin_in, .fprog_valid_in, .fprog_cmd_in,
    .fprog_arg_in, .fprog_busy_out, .fprog_done_out, .fprog_err_out,
    .fprog_rdata_out, .irq_out, .fast_prog_mode_out, .flash_standby_out,
    .brownout_detector_en_out, .brownout_reset_en_out,
    .boot_from_flash_out, .calib_bits_out);
  efcu_fetch_master fm_u (.ref_clk_in(ref_clk_in),
    .fetch_ready_in(fetch_ready_out), .fetch_ack_in(fetch_ack_out),
    .fetch_err_in(fetch_err_out), .fetch_data_in(fetch_data_out),
    .fetch_req_out(fetch_req_in), .fetch_addr_out(fetch_addr_in),
    .fetch_dbg_out(fetch_dbg_in));
  initial
    forever #2 ref_clk_in = ~ref_clk_in;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      @(negedge ref_clk_in);
      d = reg_rdata_out;
    end
  endtask
  // gather status bits; each read clears the done and error flags
  task cmd(input [3:0] c, input [15:0] arg);
    integer n;
    begin
      wr(`EFCU_A_CMD, {arg, 12'h000, c});
      s = 32'h0;
      q = 32'h0;
      for (n = 0; q[0] !== 1'b1 && n < 40000; n = n + 1)
      begin
        rd(`EFCU_A_STAT, q);
        s = s | q;
        if (q[0] === 1'b0) chk(flash_standby_out, 32'h0);
      end
    end
  endtask
  task fp(input [3:0] c, input [15:0] arg);
    integer n;
    begin
      n = 0;
      @(negedge ref_clk_in);
      while (fprog_busy_out !== 1'b0 && n < 64)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      @(posedge ref_clk_in);
      fprog_valid_in <= 1'b1;
      fprog_cmd_in <= c;
      fprog_arg_in <= arg;
      @(posedge ref_clk_in);
      fprog_valid_in <= 1'b0;
      @(negedge ref_clk_in);
      while (fprog_done_out !== 1'b1 && fprog_err_out !== 1'b1 && n < 999)
      begin
        @(negedge ref_clk_in);
        n = n + 1;
      end
      e = fprog_err_out;
      q = fprog_rdata_out;
    end
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 95000)
    begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rd(`EFCU_A_MODE, q);
    chk(q, 32'h00040001);
    rd(4'h2, q);
    chk(q, 32'h0);
    chk(flash_standby_out, 32'h1);
    chk(calib_bits_out, `EFCU_CALIB_RST);
    // timing 0 keeps full erase in budget
    wr(`EFCU_A_MODE, 32'h00000301);
    rd(`EFCU_A_MODE, q);
    chk(q, 32'h00000301);
    for (i = 0; i < 8; i = i + 1)
    begin
      @(posedge ref_clk_in);
      {test_mode_pin_in, program_select_1_in, program_select_0_in} <= i;
      repeat (3) @(negedge ref_clk_in);
      chk(fast_prog_mode_out, (i == 7) ? 32'h1 : 32'h0);
    end
    for (i = 0; i < 64; i = i + 1)
    begin
      @(posedge ref_clk_in);
      wbuf_wr_in <= 1'b1;
      wbuf_addr_in <= i;
      wbuf_data_in <= 32'h10000000 + i;
    end
    @(posedge ref_clk_in);
    wbuf_wr_in <= 1'b0;
    cmd(`EFCU_C_PROG, 16'h0001);
    chk(s[3:0], 32'h3);
    fm_u.fetch(18'h0010C, 1'b0, q, e);
    chk(q, 32'h10000003);
    fm_u.fetch(18'h0010E, 1'b0, q, e);
    chk(q, 32'h10000003);
    fm_u.fetch(18'h00110, 1'b0, q, e);
    chk(q, 32'h10000004);
    cmd(`EFCU_C_SLOCK, 16'h0001);
    chk(s[17:16], 32'h1);
    wr(`EFCU_A_CMD, {16'h0001, 12'h000, `EFCU_C_PERASE});
    repeat (4) @(negedge ref_clk_in);
    chk(irq_out, 32'h1);
    rd(`EFCU_A_STAT, q);
    chk(q[3:0], 32'h7);
    fm_u.fetch(18'h00100, 1'b0, q, e);
    chk(q, 32'h10000000);
    cmd(`EFCU_C_CLOCK, 16'h003F);
    chk(s[17:16], 32'h0);
    cmd(4'hF, 16'h0000);
    chk(s[3], 32'h1);
    fp(`EFCU_C_READ, 16'h0043);
    chk(q, 32'h10000003);
    fp(`EFCU_C_PERASE, 16'h0001);
    chk(e, 32'h0);
    fm_u.fetch(18'h0010C, 1'b0, q, e);
    chk(q, `EFCU_ERASED);
    for (i = 0; i < 3; i = i + 1)
      cmd(`EFCU_C_SGP, i);
    chk({brownout_reset_en_out, brownout_detector_en_out}, 32'h3);
    rd(`EFCU_A_NVM, q);
    chk(q, {16'h0, `EFCU_CALIB_RST, 8'h07});
    chk(boot_from_flash_out, 32'h0);
    cmd(`EFCU_C_CGP, 16'h0001);
    chk({brownout_reset_en_out, brownout_detector_en_out}, 32'h1);
    cmd(`EFCU_C_SGP, 16'h0001);
    cmd(`EFCU_C_SLOCK, 16'h0040);
    chk(s[17:16], 32'h2);
    cmd(`EFCU_C_SSEC, 16'h0000);
    chk(s[4], 32'h1);
    fm_u.fetch(18'h00100, 1'b1, q, e);
    chk(e, 32'h1);
    fm_u.fetch(18'h00108, 1'b0, q, e);
    chk({e, q[30:0]}, {1'b0, 31'h7FFFFFFF});
    fp(`EFCU_C_READ, 16'h0042);
    chk(e, 32'h1);
    // short pulse is filtered
    @(posedge ref_clk_in);
    erase_pin_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    erase_pin_in <= 1'b0;
    rd(`EFCU_A_STAT, q);
    chk(q[17:16], 32'h2);
    @(posedge ref_clk_in);
    erase_pin_in <= 1'b1;
    repeat (26) @(posedge ref_clk_in);
    erase_pin_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rd(`EFCU_A_STAT, q);
    chk({q[31:16], 11'h0, q[4]}, 32'h1);
    rd(`EFCU_A_NVM, q);
    chk(q, {16'h0, `EFCU_CALIB_RST, 8'h00});
    chk({brownout_reset_en_out, brownout_detector_en_out}, 32'h0);
    cmd(`EFCU_C_FERASE, 16'h0000);
    chk(q[4:2], 32'h0);
    fm_u.fetch(18'h00000, 1'b1, q, e);
    chk({e, q[30:0]}, {1'b0, 31'h7FFFFFFF});
    repeat (4) @(negedge ref_clk_in);
    chk(flash_standby_out, 32'h1);
    tally_and_finish;
  end
endmodule // efcu_top_tb
